// ### src/fdi_regs.svh
`ifndef FDI_REGS_SVH
`define FDI_REGS_SVH
// What this block does
// - Index low 4 ms once per 200 ms
// - Track-zero low while head on outermost track
// - Ready high when door open or no disk
// - Ready low only after two index pulses
// - Read data idles high, low pulse per transition
// - FM pulse spacing 4 us or 8 us nominal
// - Write protect low while notched disk inserted
// - Write protect blocks writing despite write gate
// - Host waits 200 ms after power-up
// - Host steps outward until track zero
// - Only selected drive responds and drives cable
// - Host sets direction, then one step per track
// - Head moves on step pulse trailing edge
// - Side zero when side high, one when low
// - Host uses FM single, MFM double density
// - Precompensation optional, at most 7.5 percent
// - Write gate over 250 ms after motor on
// - Read data valid within 1000 us after write
// - Step outward when direction high, else inward
// - Host waits over 100 us after side change

// Clock rate in kHz and MHz
`define FDI_CLK_KHZ        100000
`define FDI_CLK_MHZ        100
// Index timing in ms
`define FDI_INDEX_MS       4
`define FDI_REV_MS         200
`define FDI_INDEX_CYC      (`FDI_INDEX_MS * `FDI_CLK_KHZ)
`define FDI_REV_CYC        (`FDI_REV_MS * `FDI_CLK_KHZ)
// FM cell timing in ns
`define FDI_FM_SHORT_NS    4000
`define FDI_FM_LONG_NS     8000
`define FDI_FM_SHORT_CYC   (`FDI_FM_SHORT_NS * `FDI_CLK_MHZ / 1000)
`define FDI_FM_LONG_CYC    (`FDI_FM_LONG_NS * `FDI_CLK_MHZ / 1000)
// Read pulse width in ns
`define FDI_RD_PULSE_NS    200
`define FDI_RD_PULSE_CYC   (`FDI_RD_PULSE_NS * `FDI_CLK_MHZ / 1000)
// Host waits
`define FDI_PWRUP_MS       200
`define FDI_PWRUP_CYC      (`FDI_PWRUP_MS * `FDI_CLK_KHZ)
`define FDI_MOTOR_MS       251
`define FDI_MOTOR_CYC      (`FDI_MOTOR_MS * `FDI_CLK_KHZ)
`define FDI_RECOV_US       1000
`define FDI_RECOV_CYC      (`FDI_RECOV_US * `FDI_CLK_MHZ)
`define FDI_SIDE_US        101
`define FDI_SIDE_CYC       (`FDI_SIDE_US * `FDI_CLK_MHZ)
// Step pulse low time in ns, step gap in us
`define FDI_STEP_LOW_NS    1000
`define FDI_STEP_LOW_CYC   (`FDI_STEP_LOW_NS * `FDI_CLK_MHZ / 1000)
`define FDI_STEP_GAP_US    3000
`define FDI_STEP_GAP_CYC   (`FDI_STEP_GAP_US * `FDI_CLK_MHZ)
// Index pulses needed for ready
`define FDI_READY_INDEX    2
`endif

// ### src/fdi_pkg.sv
package fdi_pkg;
	// Wide enough for the longest timing count at the full clock rate
	typedef logic [24:0] fdi_cnt_t;
	typedef logic [6:0]  fdi_trk_t;
	typedef enum logic [2:0] {
		FDI_H_PWRUP = 3'b000,
		FDI_H_HOME  = 3'b001,
		FDI_H_IDLE  = 3'b011,
		FDI_H_SEEK  = 3'b010,
		FDI_H_SPIN  = 3'b110,
		FDI_H_XFER  = 3'b111,
		FDI_H_RECOV = 3'b101
	} fdi_host_e;
endpackage : fdi_pkg

// ### src/fdi_cable_if.sv
`timescale 1ns/10ps
// Shared cable, all lines active low; open-collector outputs carry an enable
interface fdi_cable_if;
	logic sel_n;
	logic motor_n;
	logic dir_n;
	logic step_n;
	logic side_n;
	logic wgate_n;
	logic wdata_n;
	logic index_n_o;
	logic index_oe;
	logic trk0_n_o;
	logic trk0_oe;
	logic ready_n_o;
	logic ready_oe;
	logic rdata_n_o;
	logic rdata_oe;
	logic wprot_n_o;
	logic wprot_oe;
	// Resolved open-collector levels, pulled high
	logic index_n;
	logic trk0_n;
	logic ready_n;
	logic rdata_n;
	logic wprot_n;
	assign index_n = index_oe ? index_n_o : 1'b1;
	assign trk0_n  = trk0_oe ? trk0_n_o : 1'b1;
	assign ready_n = ready_oe ? ready_n_o : 1'b1;
	assign rdata_n = rdata_oe ? rdata_n_o : 1'b1;
	assign wprot_n = wprot_oe ? wprot_n_o : 1'b1;
	modport drive (
		input  sel_n, motor_n, dir_n, step_n, side_n, wgate_n, wdata_n,
		output index_n_o, index_oe, trk0_n_o, trk0_oe, ready_n_o, ready_oe,
		output rdata_n_o, rdata_oe, wprot_n_o, wprot_oe
	);
	modport host (
		output sel_n, motor_n, dir_n, step_n, side_n, wgate_n, wdata_n,
		input  index_n, trk0_n, ready_n, rdata_n, wprot_n
	);
endinterface : fdi_cable_if

// ### src/fdi_drive.sv
`timescale 1ns/10ps
`include "fdi_regs.svh"
module fdi_drive #(
	parameter int TRACKS   = 80,
	parameter int REV_CYC  = `FDI_REV_CYC,
	parameter int IDX_CYC  = `FDI_INDEX_CYC,
	parameter int RECOV_CYC = `FDI_RECOV_CYC
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Cable
	fdi_cable_if.drive         cab,
	// Media side
	input  wire logic          disk_present,
	input  wire logic          door_closed,
	input  wire logic          disk_protected,
	input  wire logic          flux_in,
	output logic               head_side,
	output fdi_pkg::fdi_trk_t  head_track,
	output logic               write_enable,
	output logic               write_flux
);
	import fdi_pkg::*;

	typedef struct packed {
		logic [1:0] sel_s;
		logic [1:0] step_s;
		logic [1:0] dir_s;
		logic [1:0] side_s;
		logic [1:0] wg_s;
		logic [1:0] wd_s;
		logic [1:0] flux_s;
		logic [1:0] mp_s;
		logic [1:0] wp_s;
		logic       step_l;
		logic       wd_l;
		logic       flux_l;
		fdi_cnt_t   rev;
		logic [1:0] idx_seen;
		logic [7:0] rd_w;
		fdi_cnt_t   recov;
		fdi_trk_t   trk;
		logic       side;
		logic       wen;
		logic       wflux;
	} fdi_drv_s;

	fdi_drv_s st_q;
	fdi_drv_s st_d;
	logic     sel;
	logic     media_ok;
	logic     protect;

	// Synchronised levels
	assign sel      = st_q.sel_s[1];
	assign media_ok = st_q.mp_s[1];
	assign protect  = st_q.wp_s[1];

	// Next state
	always_comb begin
		st_d        = st_q;
		st_d.sel_s  = {st_q.sel_s[0], ~cab.sel_n};
		st_d.step_s = {st_q.step_s[0], cab.step_n};
		st_d.dir_s  = {st_q.dir_s[0], cab.dir_n};
		st_d.side_s = {st_q.side_s[0], cab.side_n};
		st_d.wg_s   = {st_q.wg_s[0], cab.wgate_n};
		st_d.wd_s   = {st_q.wd_s[0], cab.wdata_n};
		st_d.flux_s = {st_q.flux_s[0], flux_in};
		st_d.mp_s   = {st_q.mp_s[0], disk_present & door_closed};
		st_d.wp_s   = {st_q.wp_s[0], disk_present & disk_protected};
		st_d.step_l = st_q.step_s[1];
		st_d.wd_l   = st_q.wd_s[1];
		st_d.flux_l = st_q.flux_s[1];
		// Revolution counter runs while a disk is in and the door is closed, whatever the motor line
		if (!media_ok) begin
			st_d.rev      = '0;
			st_d.idx_seen = '0;
		end else if (st_q.rev == fdi_cnt_t'(REV_CYC - 1)) begin
			st_d.rev = '0;
			if (st_q.idx_seen != 2'(`FDI_READY_INDEX)) begin
				st_d.idx_seen = st_q.idx_seen + 2'd1;
			end
		end else begin
			st_d.rev = st_q.rev + 25'h000_0001;
		end
		// Head stepping on trailing edge, only while selected
		if (sel && !st_q.step_l && st_q.step_s[1]) begin
			if (st_q.dir_s[1]) begin
				if (st_q.trk != '0) begin
					st_d.trk = st_q.trk - 7'd1;
				end
			end else if (st_q.trk != fdi_trk_t'(TRACKS - 1)) begin
				st_d.trk = st_q.trk + 7'd1;
			end
		end
		// Side follows input while selected
		if (sel) begin
			st_d.side = ~st_q.side_s[1];
		end
		// Write path, blocked by protect
		st_d.wen = sel && !st_q.wg_s[1] && !protect && media_ok;
		if (st_q.wen && st_q.wd_l && !st_q.wd_s[1]) begin
			st_d.wflux = ~st_q.wflux;
		end
		// Read recovery window after write gate release, even if protect blocked the write
		if (sel && !st_q.wg_s[1]) begin
			st_d.recov = fdi_cnt_t'(RECOV_CYC / 2);
		end else if (st_q.recov != '0) begin
			st_d.recov = st_q.recov - 25'h000_0001;
		end
		// Read pulse stretcher per flux transition, silent while the gate is low
		if (st_q.rd_w != '0) begin
			st_d.rd_w = st_q.rd_w - 8'h01;
		end else if (st_q.flux_l != st_q.flux_s[1] && st_q.wg_s[1] && st_q.recov == '0) begin
			st_d.rd_w = 8'(`FDI_RD_PULSE_CYC);
		end
		if (rst) begin
			st_d          = '0;
			st_d.sel_s    = '0;
			st_d.step_s   = 2'b11;
			st_d.wg_s     = 2'b11;
			st_d.wd_s     = 2'b11;
			st_d.step_l   = 1'b1;
			st_d.wd_l     = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	// Cable outputs, driven only while selected
	always_comb begin
		cab.index_oe  = sel;
		cab.trk0_oe   = sel;
		cab.ready_oe  = sel;
		cab.rdata_oe  = sel;
		cab.wprot_oe  = sel;
		cab.index_n_o = !(media_ok && st_q.rev < fdi_cnt_t'(IDX_CYC));
		cab.trk0_n_o  = (st_q.trk != '0);
		cab.ready_n_o = !(media_ok && st_q.idx_seen == 2'(`FDI_READY_INDEX));
		cab.rdata_n_o = (st_q.rd_w == '0);
		cab.wprot_n_o = !protect;
	end

	assign head_side    = st_q.side;
	assign head_track   = st_q.trk;
	assign write_enable = st_q.wen;
	assign write_flux   = st_q.wflux;
endmodule : fdi_drive

// ### src/fdi_host.sv
`timescale 1ns/10ps
`include "fdi_regs.svh"
module fdi_host #(
	parameter int PWRUP_CYC = `FDI_PWRUP_CYC,
	parameter int MOTOR_CYC = `FDI_MOTOR_CYC,
	parameter int RECOV_CYC = `FDI_RECOV_CYC,
	parameter int GAP_CYC   = `FDI_STEP_GAP_CYC
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Cable
	fdi_cable_if.host          cab,
	// User request
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic          req_side,
	input  fdi_pkg::fdi_trk_t  req_track,
	input  wire logic          wr_flux,
	input  wire logic          xfer_end,
	output logic               req_ready,
	output logic               xfer_active,
	output logic               rd_pulse,
	output logic               homed,
	output logic               disk_ready,
	output logic               protected_disk
);
	import fdi_pkg::*;

	typedef struct packed {
		fdi_host_e  state;
		fdi_cnt_t   cnt;
		fdi_trk_t   trk;
		fdi_trk_t   tgt;
		logic       wr;
		logic       side;
		logic       dir;
		logic       step;
		logic [1:0] t0_s;
		logic [1:0] rdy_s;
		logic [1:0] wp_s;
		logic [1:0] rd_s;
		logic       rd_l;
		logic       rdp;
		logic       wdat;
	} fdi_host_s;

	fdi_host_s st_q;
	fdi_host_s st_d;

	// Next state
	always_comb begin
		st_d       = st_q;
		st_d.t0_s  = {st_q.t0_s[0], ~cab.trk0_n};
		st_d.rdy_s = {st_q.rdy_s[0], ~cab.ready_n};
		st_d.wp_s  = {st_q.wp_s[0], ~cab.wprot_n};
		st_d.rd_s  = {st_q.rd_s[0], ~cab.rdata_n};
		st_d.rd_l  = st_q.rd_s[1];
		st_d.rdp   = st_q.rd_s[1] && !st_q.rd_l;
		st_d.wdat  = wr_flux;
		if (st_q.cnt != '0) begin
			st_d.cnt = st_q.cnt - 25'h000_0001;
		end
		st_d.step = 1'b0;
		unique case (st_q.state)
			FDI_H_PWRUP: begin
				if (st_q.cnt == '0) begin
					st_d.state = FDI_H_HOME;
					st_d.dir   = 1'b1;
					st_d.cnt   = fdi_cnt_t'(MOTOR_CYC);
				end
			end
			FDI_H_HOME: begin
				if (st_q.t0_s[1]) begin
					st_d.state = FDI_H_IDLE;
					st_d.trk   = '0;
				end else if (st_q.cnt < fdi_cnt_t'(`FDI_STEP_LOW_CYC)) begin
					st_d.step = 1'b1;
					if (st_q.cnt == '0) begin
						st_d.cnt = fdi_cnt_t'(GAP_CYC);
					end
				end
			end
			FDI_H_IDLE: begin
				if (req_valid) begin
					st_d.tgt   = req_track;
					st_d.wr    = req_write;
					st_d.state = FDI_H_SEEK;
					st_d.dir   = (req_track < st_q.trk);
					// Never shorten a pending wait, so the motor-on delay survives
					if (req_side != st_q.side && st_q.cnt < fdi_cnt_t'(`FDI_SIDE_CYC)) begin
						st_d.cnt = fdi_cnt_t'(`FDI_SIDE_CYC);
					end else if (st_q.cnt < fdi_cnt_t'(GAP_CYC)) begin
						st_d.cnt = fdi_cnt_t'(GAP_CYC); // Full step gap before the first step
					end
					st_d.side  = req_side;
				end
			end
			FDI_H_SEEK: begin
				if (st_q.trk == st_q.tgt) begin
					if (st_q.cnt == '0) begin
						st_d.state = FDI_H_SPIN;
					end
				end else if (st_q.cnt < fdi_cnt_t'(`FDI_STEP_LOW_CYC)) begin
					st_d.step = 1'b1;
					if (st_q.cnt == '0) begin
						st_d.cnt = fdi_cnt_t'(GAP_CYC);
						st_d.trk = st_q.dir ? st_q.trk - 7'd1 : st_q.trk + 7'd1;
					end
				end
			end
			FDI_H_SPIN: begin
				// Protected writes still raise the gate; the drive refuses them
				if (st_q.rdy_s[1] && st_q.cnt == '0) begin
					st_d.state = FDI_H_XFER;
				end
			end
			FDI_H_XFER: begin
				if (xfer_end) begin
					st_d.state = st_q.wr ? FDI_H_RECOV : FDI_H_IDLE;
					st_d.cnt   = fdi_cnt_t'(RECOV_CYC);
				end
			end
			FDI_H_RECOV: begin
				if (st_q.cnt == '0) begin
					st_d.state = FDI_H_IDLE;
				end
			end
			default: st_d.state = FDI_H_PWRUP;
		endcase
		if (rst) begin
			st_d       = '0;
			st_d.state = FDI_H_PWRUP;
			st_d.cnt   = fdi_cnt_t'(PWRUP_CYC);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	// Cable outputs, host keeps a single drive selected
	always_comb begin
		cab.sel_n   = 1'b0;
		cab.motor_n = (st_q.state == FDI_H_PWRUP);
		cab.dir_n   = st_q.dir; // High line steps outward
		cab.step_n  = ~st_q.step;
		cab.side_n  = ~st_q.side;
		cab.wgate_n = ~(st_q.state == FDI_H_XFER && st_q.wr);
		// Raw cells passed through with no precompensation
		cab.wdata_n = ~(st_q.state == FDI_H_XFER && st_q.wr && st_q.wdat);
	end

	assign req_ready      = (st_q.state == FDI_H_IDLE);
	assign xfer_active    = (st_q.state == FDI_H_XFER);
	assign rd_pulse       = st_q.rdp && st_q.state == FDI_H_XFER && !st_q.wr;
	assign homed          = (st_q.state != FDI_H_PWRUP) && (st_q.state != FDI_H_HOME);
	assign disk_ready     = st_q.rdy_s[1];
	assign protected_disk = st_q.wp_s[1];
endmodule : fdi_host

// ### sim/fdi_cable_assertions.sv
`timescale 1ns/10ps
`include "fdi_regs.svh"
module fdi_cable_assertions #(
	parameter int IDX_CYC = 20,
	parameter int REV_CYC = 1000,
	parameter int PWR_CYC = 300,
	parameter int MOT_MIN = 2500
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host to drive
	input wire logic sel_n,
	input wire logic motor_n,
	input wire logic dir_n,
	input wire logic step_n,
	input wire logic side_n,
	input wire logic wgate_n,
	// Drive to host
	input wire logic index_oe,
	input wire logic trk0_oe,
	input wire logic index_n,
	input wire logic trk0_n,
	input wire logic rdata_n
);
	int   lo_q, per_q, rd_q, pw_q, mot_q, sd_q, wg_q;
	logic idx_q, side_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Low run lengths and time since cable events
	always_ff @(posedge clk) begin
		if (rst) begin
			lo_q   <= 0;
			per_q  <= 0;
			rd_q   <= 0;
			pw_q   <= 0;
			mot_q  <= 0;
			sd_q   <= 0;
			wg_q   <= 0;
			idx_q  <= 1'h1;
			side_q <= side_n;
		end else begin
			lo_q   <= index_n ? 0 : lo_q + 1;
			per_q  <= (idx_q && !index_n) ? 1 : (per_q == 0 ? 0 : per_q + 1);
			rd_q   <= rdata_n ? 0 : rd_q + 1;
			pw_q   <= pw_q + 1;
			mot_q  <= motor_n ? 0 : mot_q + 1;
			sd_q   <= (side_q != side_n) ? 0 : sd_q + 1;
			wg_q   <= wgate_n ? 0 : wg_q + 1;
			idx_q  <= index_n;
			side_q <= side_n;
		end
	end
	// Drive side
	AST_IDX_WIDTH: assert property ($rose(index_n) |-> lo_q == IDX_CYC)
		else $error("index pulse width wrong");
	AST_IDX_PERIOD: assert property ($fell(index_n) && per_q != 0 |-> per_q == REV_CYC)
		else $error("index period wrong");
	AST_RD_WIDTH: assert property ($rose(rdata_n) |-> rd_q == `FDI_RD_PULSE_CYC)
		else $error("read pulse width wrong");
	AST_RD_QUIET: assert property (!wgate_n && wg_q >= 23 |-> rdata_n)
		else $error("read pulse while writing");
	AST_SEL_OFF: assert property (sel_n [*5] |-> !index_oe && !trk0_oe)
		else $error("unselected drive drives cable");
	AST_SEL_ON: assert property ((!sel_n) [*5] |-> index_oe && trk0_oe)
		else $error("selected drive silent");
	AST_STEP_IN: assert property ($rose(step_n) && !dir_n && !sel_n |-> ##[1:8] trk0_n)
		else $error("inward step left track zero flag");
	// Host side
	AST_PWR_WAIT: assert property (pw_q < PWR_CYC |-> step_n && wgate_n)
		else $error("host active during power up");
	AST_MOTOR_WAIT: assert property ($fell(wgate_n) |-> mot_q > MOT_MIN)
		else $error("write gate too soon after motor on");
	AST_SIDE_WAIT: assert property ($fell(wgate_n) |-> sd_q > 100 * `FDI_CLK_MHZ)
		else $error("write too soon after side change");
	AST_DIR_HOLD: assert property (!step_n |-> $stable(dir_n))
		else $error("direction moved during step");
endmodule : fdi_cable_assertions

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
	import fdi_pkg::*;
	localparam int REV = 1000;
	localparam int IDX = 20;
	localparam int RCV = 200;
	logic     clk, rst, disk_present, door_closed, disk_protected, flux_in;
	logic     req_valid, req_write, req_side, wr_flux, xfer_end;
	logic     head_side, write_enable, req_ready, xfer_active, rd_pulse;
	logic     homed, disk_ready, protected_disk, wflux, wf;
	fdi_trk_t req_track, head_track, trk2;
	int       n_errors, num_checks, k, n;
	fdi_cable_if cab ();
	fdi_cable_if cab2 ();
	fdi_drive #(.REV_CYC(REV), .IDX_CYC(IDX), .RECOV_CYC(RCV)) fdi_drive_i (.clk(clk),
		.rst(rst), .cab(cab), .disk_present(disk_present), .door_closed(door_closed),
		.disk_protected(disk_protected), .flux_in(flux_in), .head_side(head_side),
		.head_track(head_track), .write_enable(write_enable), .write_flux(wflux));
	// Second drive on a cable steered by the bench
	if (1) begin : alt
		fdi_drive #(.REV_CYC(REV), .IDX_CYC(IDX), .RECOV_CYC(RCV)) fdi_drive_i (.clk(clk),
			.rst(rst), .cab(cab2), .disk_present(disk_present), .door_closed(door_closed),
			.disk_protected(disk_protected), .flux_in(flux_in), .head_side(),
			.head_track(trk2), .write_enable(), .write_flux());
	end
	fdi_host #(.PWRUP_CYC(300), .MOTOR_CYC(2510), .RECOV_CYC(RCV), .GAP_CYC(110)) fdi_host_i (
		.clk(clk), .rst(rst), .cab(cab), .req_valid(req_valid), .req_write(req_write),
		.req_side(req_side), .req_track(req_track), .wr_flux(wr_flux), .xfer_end(xfer_end),
		.req_ready(req_ready), .xfer_active(xfer_active), .rd_pulse(rd_pulse), .homed(homed),
		.disk_ready(disk_ready), .protected_disk(protected_disk));
	fdi_cable_assertions fdi_cable_assertions_i (.clk(clk), .rst(rst), .sel_n(cab.sel_n),
		.motor_n(cab.motor_n), .dir_n(cab.dir_n), .step_n(cab.step_n), .side_n(cab.side_n),
		.wgate_n(cab.wgate_n), .index_oe(cab.index_oe), .trk0_oe(cab.trk0_oe),
		.index_n(cab.index_n), .trk0_n(cab.trk0_n), .rdata_n(cab.rdata_n));
	// Clock
	always #5 clk = ~clk;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task conclude;
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	// One step pulse on the bench cable
	task stp(input logic d);
		cab2.dir_n = d;
		repeat (10) @(negedge clk);
		cab2.step_n = 0;
		repeat (100) @(negedge clk);
		cab2.step_n = 1;
		repeat (20) @(negedge clk);
	endtask : stp
	// One host transfer with jittered flux cells
	task xfer(input int t, input logic w, input logic s, input logic p);
		disk_protected = p;
		for (k = 0; k < 9000 && req_ready !== 1'h1; k++) @(negedge clk);
		chk("req ready", req_ready, 1);
		req_valid = 1;
		req_write = w;
		req_side = s;
		req_track = t[6:0];
		@(negedge clk);
		req_valid = 0;
		for (k = 0; k < 30000 && xfer_active !== 1'h1; k++) @(negedge clk);
		chk("xfer active", xfer_active, 1);
		chk("track", head_track, t);
		chk("trk0", cab.trk0_n, t != 0);
		chk("head side", head_side, s);
		chk("side line", cab.side_n, !s);
		chk("wprot", cab.wprot_n, !p);
		chk("prot", protected_disk, p);
		n = 0;
		repeat (5) begin
			// A rising write level makes a falling write pulse, one medium flip
			if (w && !p && !wr_flux) wf = !wf;
			flux_in = !flux_in;
			wr_flux = !wr_flux;
			repeat (320 + $urandom % 161) begin
				@(negedge clk);
				n += rd_pulse;
			end
		end
		chk("wr en", write_enable, w && !p);
		chk("wr flux", wflux, wf);
		chk("reads", n, w ? 0 : 5);
		xfer_end = 1;
		@(negedge clk);
		xfer_end = 0;
	endtask : xfer
	// Main sequence
	initial begin
		{clk, rst, disk_present} = 3'h7;
		{door_closed, disk_protected, flux_in, req_valid, req_write, req_side} = 6'h00;
		{wf, wr_flux, xfer_end, req_track, n_errors, num_checks} = 0;
		{cab2.sel_n, cab2.motor_n, cab2.dir_n, cab2.step_n} = 4'hf;
		{cab2.side_n, cab2.wgate_n, cab2.wdata_n} = 3'h7;
		k = $urandom(32'hf9c3);
		repeat (20) @(negedge clk);
		rst = 0;
		stp(0);
		chk("silent trk", trk2, 0);
		chk("silent oe", {cab2.index_oe, cab2.trk0_oe, cab2.rdata_oe}, 0);
		cab2.sel_n = 0;
		stp(0);
		chk("in", trk2, 1);
		stp(1);
		chk("out", cab2.trk0_n, 0);
		repeat (3000) @(negedge clk);
		chk("door open", cab.ready_n, 1);
		chk("not rdy", disk_ready, 0);
		door_closed = 1;
		for (k = 0, n = 0; k < 5000 && cab.ready_n !== 1'h0; k++) begin
			@(negedge clk);
			n += !cab.index_n;
		end
		chk("idx first", n >= 2 * IDX, 1);
		chk("rdy line", cab.ready_n, 0);
		for (k = 0; k < 2000 && cab.index_n !== 1'h0; k++) @(negedge clk);
		for (n = 0; n < 2000 && cab.index_n === 1'h0; n++) @(negedge clk);
		chk("idx width", n, IDX);
		for (k = n; k < 2000 && cab.index_n !== 1'h0; k++) @(negedge clk);
		chk("idx period", k, REV);
		chk("rdy", disk_ready, 1);
		chk("homed", homed, 1);
		xfer(79, 0, $urandom % 2, 0);
		xfer(0, 0, $urandom % 2, 0);
		xfer($urandom % 80, 0, $urandom % 2, 0);
		xfer($urandom % 80, 1, 1, 1);
		xfer($urandom % 80, 1, 0, 0);
		conclude();
	end
	// Watchdog
	initial begin
		repeat (120000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule : tb
